/* hdl/bridge_status_sleep_pins.v */
// Status, reset and power-state pin logic of the bridge
`timescale 1ns/10ps
`include "bridge_pins_map.vh"
module bridge_status_sleep_pins #(
  parameter [17:0] presence_deadline_cyc = `PRESENCE_DEADLINE_CYC
) (
  // Clock and reset
  input wire sys_clk_in,
  input wire reset_n_in,
  // Internal reset source (power-up, power fail)
  input wire internal_reset_in,
  // Shared reset pin
  input wire reset_pin_in,
  output wire reset_pin_out,
  output wire reset_pin_oe_n_out,
  // Power-state pins
  input wire wake_pin_in,
  input wire sleep_pin_in,
  output reg awake_out,
  // Events from the bus front end and I2C engine
  input wire bus_reset_pulse_in,
  input wire device_cmd_in,
  input wire cmd_has_packet_in,
  input wire packet_crc_done_in,
  input wire invalid_cmd_in,
  input wire crc_fail_in,
  input wire i2c_nack_in,
  input wire i2c_done_in,
  // Status pins
  output reg error_flag_n_out,
  output reg busy_n_out,
  output reg expect_packet_n_out,
  // Power-up presence, bus gating and core reset
  output reg presence_out,
  output wire bus_enable_out,
  output wire core_reset_n_out
);
  localparam st_run = 1'b0;
  localparam st_sleep = 1'b1;

  reg state;
  reg next_state;
  reg [15:0] por_cnt;
  reg int_reset;
  reg [17:0] pres_cnt;
  reg pres_done;
  wire pin_level;
  wire wake_rise;
  wire sleep_fall;
  wire any_error;
  wire core_rst;
  wire bus_reset_ok;
  wire cmd_ok;
  wire crc_ok;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  sync_edge u_rst_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(reset_pin_in),
    .level_out(pin_level),
    .rise_out(),
    .fall_out()
  );

  sync_edge u_wake_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(wake_pin_in),
    .level_out(),
    .rise_out(wake_rise),
    .fall_out()
  );

  sync_edge u_sleep_sync (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .async_in(sleep_pin_in),
    .level_out(),
    .rise_out(),
    .fall_out(sleep_fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reset pin: stretched internal reset drives it low, else released

  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      por_cnt <= 16'h0000;
      int_reset <= 1'b1;
    end else if (internal_reset_in) begin
      // A new cause restarts the stretch, so the pin cannot blip high
      por_cnt <= 16'h0000;
      int_reset <= 1'b1;
    end else if (por_cnt != `POR_CYCLES) begin
      por_cnt <= por_cnt + 16'h0001;
      int_reset <= 1'b1;
    end else begin
      int_reset <= 1'b0;
    end
  end

  // Open drain: enable low only while driving low; pull-up is in the pad
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe_n_out = ~int_reset;
  // An external low on the shared line resets the core too
  assign core_reset_n_out = ~int_reset & pin_level;

  assign core_rst = int_reset | ~pin_level;

  ////////////////////////////////////////////////////////////////////////
  // Sleep and wake
  // Pin edges act three cycles late; a pin pulse shorter than about one
  // clock cycle may be lost in the synchroniser

  always @* begin
    next_state = state;
    case (state)
      st_run: begin
        if (sleep_fall) begin
          next_state = st_sleep;
        end
      end
      st_sleep: begin
        // Wake edges outside sleep never reach here
        if (wake_rise) begin
          next_state = st_run;
        end
      end
      default: next_state = st_run;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (!reset_n_in || core_rst) begin
      state <= st_run;
      awake_out <= 1'b1;
    end else begin
      state <= next_state;
      awake_out <= (next_state == st_run);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status outputs

  // A bus event counts only while the front end is open
  function bus_gate;
    input pulse;
    input gate_open;
    begin
      bus_gate = pulse & gate_open;
    end
  endfunction

  // Bus events count only while awake and not busy
  assign bus_enable_out = busy_n_out & (state == st_run) & pres_done;
  assign bus_reset_ok = bus_gate(bus_reset_pulse_in, bus_enable_out);
  assign cmd_ok = bus_gate(device_cmd_in, bus_enable_out);
  assign crc_ok = bus_gate(packet_crc_done_in, bus_enable_out);
  // Errors come from the decoder, the CRC check and the I2C engine
  assign any_error = invalid_cmd_in | crc_fail_in | i2c_nack_in;

  // Set wins over clear: an error in the bus reset cycle still shows
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || core_rst) begin
      error_flag_n_out <= 1'b1;
    end else if (any_error) begin
      error_flag_n_out <= 1'b0;
    end else if (bus_reset_ok) begin
      error_flag_n_out <= 1'b1;
    end
  end

  // A taken-in checksum starts the I2C transfer, its end releases busy
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || core_rst) begin
      busy_n_out <= 1'b1;
    end else if (crc_ok) begin
      busy_n_out <= 1'b0;
    end else if (i2c_done_in) begin
      busy_n_out <= 1'b1;
    end
  end

  // Only commands that carry a packet pull the expect pin low
  always @(posedge sys_clk_in) begin
    if (!reset_n_in || core_rst) begin
      expect_packet_n_out <= 1'b1;
    end else if (crc_ok) begin
      expect_packet_n_out <= 1'b1;
    end else if (cmd_ok && cmd_has_packet_in) begin
      expect_packet_n_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up presence pulse, ends at its width or at the deadline, whichever comes first

  // Last count of the pulse; the deadline bounds it when it is shorter
  localparam [17:0] pres_width_last = `PRESENCE_WIDTH_CYC - 18'h00001;
  localparam [17:0] pres_deadline_last = presence_deadline_cyc - 18'h00001;

  always @(posedge sys_clk_in) begin
    if (!reset_n_in || int_reset) begin
      pres_cnt <= 18'h00000;
      pres_done <= 1'b0;
      presence_out <= 1'b0;
    end else if (!pres_done) begin
      pres_cnt <= pres_cnt + 18'h00001;
      presence_out <= 1'b1;
      if (pres_cnt == pres_width_last ||
          pres_cnt == pres_deadline_last) begin
        pres_done <= 1'b1;
        presence_out <= 1'b0;
      end
    end
  end

endmodule

/* hdl/bridge_pins_map.vh */
// Constants for the status, reset and power-state pin logic
// Operation
// - The reset pin accepts active-low requests from outside and is pulled up so open-drain sources can share it.
// - An internal reset drives the reset pin low for the whole reset state and releases it on leaving.
// - One rising edge on the wake input ends sleep mode.
// - Rising edges on the wake input are ignored unless the device is asleep.
// - One falling edge on the sleep input enters sleep mode.
// - The error output goes low on an invalid command, a failed CRC16 or an unacknowledged I2C transfer.
// - The error output returns high when a bus reset pulse is received.
// - The awake output is high while awake and low while asleep.
// - The busy output goes low once a packet checksum is taken in and stays low until the I2C transaction ends.
// - While busy is low all single-wire bus activity is disregarded; here invalid commands and CRC failures still pull the error output low.
// - The expecting-data output goes low after a device command and stays low until the packet has arrived.
// - The expecting-data output returns high once the trailing CRC16 is received.
// - The expecting-data output stays high for device commands without a data packet.
// - After power-up a presence pulse is issued and finished within 2 ms of power being applied.
// - Each bus transaction starts with a master reset pulse answered by a presence pulse; here presence_out pulses only after an internal reset.
`ifndef BRIDGE_PINS_MAP_VH
`define BRIDGE_PINS_MAP_VH

`define CLK_PERIOD_NS 8
// Internal reset stretch after power-up, in clock cycles
`define POR_CYCLES 16'h0040
// Power-up presence deadline (2 ms) and width (120 us) at 8 ns a cycle
`define PRESENCE_DEADLINE_CYC 18'h3d090
`define PRESENCE_WIDTH_CYC 18'h03a98
`define PRESENCE_CNT_W 18

`endif

/* hdl/sync_edge.v */
// Two-flop synchroniser with rise and fall detection
`timescale 1ns/10ps
module sync_edge (
  // Clock and reset
  input wire sys_clk_in,
  input wire reset_n_in,
  // Asynchronous level
  input wire async_in,
  // Synchronised level and edges
  output reg level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta;
  reg prev;

  // The first stage feeds only the second stage
  always @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      meta <= 1'b1;
      level_out <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= async_in;
      level_out <= meta;
      prev <= level_out;
    end
  end

  assign rise_out = level_out & ~prev;
  assign fall_out = ~level_out & prev;
endmodule

/* bench/bridge_pins_props.sv */
// Checker for the status, reset and power-state pins
`timescale 1ns/10ps
module bridge_pins_props (
  input wire sys_clk_in, reset_n_in, internal_reset_in, sleep_pin_in,
  input wire wake_pin_in, core_reset_n_out,
  input wire bus_reset_pulse_in, device_cmd_in, cmd_has_packet_in,
  input wire packet_crc_done_in, invalid_cmd_in, crc_fail_in,
  input wire i2c_nack_in, i2c_done_in, bus_enable_out, awake_out,
  input wire error_flag_n_out, busy_n_out, expect_packet_n_out,
  input wire reset_pin_oe_n_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire any_err = invalid_cmd_in | crc_fail_in | i2c_nack_in;
  // A pin-driven core reset overrides every status event
  wire go = bus_enable_out & core_reset_n_out;
  property p_err;
    any_err && core_reset_n_out |=> !error_flag_n_out;
  endproperty
  a_err: assert property (p_err) else $error("error flag missed");
  property p_eclr;
    bus_reset_pulse_in && go && !any_err |=> error_flag_n_out;
  endproperty
  a_eclr: assert property (p_eclr) else $error("error kept");
  property p_xlo;
    device_cmd_in && cmd_has_packet_in && go && !packet_crc_done_in
      |=> !expect_packet_n_out;
  endproperty
  a_xlo: assert property (p_xlo) else $error("expect not low");
  property p_xhi;
    packet_crc_done_in && go |=> expect_packet_n_out && !busy_n_out;
  endproperty
  a_xhi: assert property (p_xhi) else $error("crc end wrong");
  property p_nopk;
    device_cmd_in && !cmd_has_packet_in && go && expect_packet_n_out
      |=> expect_packet_n_out;
  endproperty
  a_nopk: assert property (p_nopk) else $error("expect toggled");
  property p_bhi; !busy_n_out && i2c_done_in |=> busy_n_out; endproperty
  a_bhi: assert property (p_bhi) else $error("busy stuck");
  property p_gate; !busy_n_out |-> !go; endproperty
  a_gate: assert property (p_gate) else $error("bus open when busy");
  property p_slp;
    $fell(sleep_pin_in) && core_reset_n_out |-> ##[2:6] !awake_out;
  endproperty
  a_slp: assert property (p_slp) else $error("no sleep");
  property p_wake;
    $rose(wake_pin_in) && !awake_out && core_reset_n_out
      |-> ##[2:6] awake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_oe;
    internal_reset_in |-> ##[1:3] !reset_pin_oe_n_out;
  endproperty
  a_oe: assert property (p_oe) else $error("reset pin not driven");
  c_busy: cover property (packet_crc_done_in && go ##1 !busy_n_out);
  c_sleep: cover property ($fell(awake_out));
  c_err: cover property ($fell(error_flag_n_out));
  c_wake: cover property ($rose(awake_out));
endmodule
bind bridge_status_sleep_pins bridge_pins_props props_i (.*);

/* bench/board_model.sv */
// Board-side model of the shared active-low reset line
`timescale 1ns/10ps
module board_model (
  input wire oe_n_in, drv_in, ext_n_in,
  output wire pin_out
);
  // Pull-up wins unless some open-drain source sinks the line
  assign pin_out = ((!oe_n_in && !drv_in) || !ext_n_in) ? 1'b0 : 1'b1;
endmodule

/* bench/tb.sv */
// Testbench for the status, reset and power-state pins
`timescale 1ns/10ps
module tb;
  logic sys_clk, rst_n, int_rst, ext_n, wake, slp;
  logic [7:0] ev;
  wire pin, pin_o, oe_n, awake, err_n, busy_n, xp_n, pres, bus_en, core_n;
  int err_total, n_checks, n_pres;
  // Event byte, then error, busy and expect levels one cycle later
  logic [10:0] rows [16] = '{11'h306, 11'h085, 11'h011, 11'h401,
    11'h301, 11'h00b, 11'h407, 11'h207, 11'h043, 11'h407, 11'h023, 11'h407,
    11'h413, 11'h407, 11'h385, 11'h00f};
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  board_model bm (.oe_n_in(oe_n), .drv_in(pin_o), .ext_n_in(ext_n),
    .pin_out(pin));
  // Short deadline keeps the power-up presence wait brief
  bridge_status_sleep_pins #(.presence_deadline_cyc(18'h00064)) uut (
    .sys_clk_in(sys_clk), .reset_n_in(rst_n), .internal_reset_in(int_rst),
    .reset_pin_in(pin), .reset_pin_out(pin_o), .reset_pin_oe_n_out(oe_n),
    .wake_pin_in(wake), .sleep_pin_in(slp), .awake_out(awake),
    .bus_reset_pulse_in(ev[7]), .device_cmd_in(ev[6]),
    .cmd_has_packet_in(ev[5]), .packet_crc_done_in(ev[4]),
    .invalid_cmd_in(ev[3]), .crc_fail_in(ev[2]), .i2c_nack_in(ev[1]),
    .i2c_done_in(ev[0]), .error_flag_n_out(err_n), .busy_n_out(busy_n),
    .expect_packet_n_out(xp_n), .presence_out(pres),
    .bus_enable_out(bus_en), .core_reset_n_out(core_n));
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task wait_en;
    for (int i = 0; i < 20000 && bus_en !== 1'b1; i++) cyc(1);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_n = 0; int_rst = 0; ext_n = 1; wake = 0; slp = 1; ev = 0;
    err_total = 0; n_checks = 0;
    cyc(6);
    rst_n = 1;
    cyc(2);
    chk("oe_n in reset", 4'h0, {3'h0, oe_n});
    chk("presence in reset", 4'h0, {3'h0, pres});
    for (int i = 0; i < 200 && pres !== 1'b1; i++) cyc(1);
    chk("presence on", 4'h1, {3'h0, pres});
    n_pres = 0;
    while (n_pres < 20000 && pres === 1'b1) begin
      n_pres++;
      cyc(1);
    end
    chk("pres width", 4'h1, {3'h0, n_pres <= 100});
    wait_en;
    chk("oe_n, enable", 4'h3, {2'h0, oe_n, bus_en});
    chk("idle pins", 4'hf, {awake, err_n, busy_n, xp_n});
    $display("test reset done");
    foreach (rows[i]) begin
      ev = rows[i][10:3];
      cyc(1);
      ev = 0;
      cyc(1);
      chk("status", {1'b1, rows[i][2:0]}, {awake, err_n, busy_n, xp_n});
    end
    $display("test rows done");
    slp = 0;
    cyc(6);
    chk("asleep", 4'h0, {3'h0, awake});
    slp = 1; wake = 1;
    cyc(6);
    chk("woken", 4'h1, {3'h0, awake});
    wake = 0;
    cyc(4);
    wake = 1;
    cyc(4);
    slp = 0;
    cyc(6);
    chk("early wake ignored", 4'h0, {3'h0, awake});
    wake = 0;
    cyc(4);
    wake = 1; slp = 1;
    cyc(6);
    chk("woken again", 4'h1, {3'h0, awake});
    $display("test sleep done");
    ev = 8'h02;
    cyc(1);
    ev = 0; ext_n = 0;
    cyc(6);
    chk("pin reset", 4'h1, {2'h0, core_n, err_n});
    ext_n = 1; int_rst = 1;
    cyc(4);
    chk("int reset pin", 4'h0, {2'h0, oe_n, pin});
    int_rst = 0;
    wait_en;
    chk("pin released", 4'h3, {2'h0, oe_n, pin});
    $display("test pin reset done");
    final_report;
  end
  initial begin
    cyc(60000);
    err_total++;
    $display("unexpected watchdog expired");
    final_report;
  end
endmodule
